// ==== rtl/adclso_map.vh ====
// Register map, command layout and timing constants of the list offset and SAR control block.
// Assumes byte addresses of eight bits on the register bus and a 32-bit data path.
//
// Contract
// - The first list pair offset is a 7-bit field that always reads zero and ignores every write.
// - Offsets count samples, scaled by two bytes for result lists and four bytes for command lists.
// - The second offset is written only while the converter is disabled or special mode access is set.
// - List A uses the zero offset and list B the programmable one, added to both command and result bases.
// - Each result is stored at the end of its conversion to an address formed from the selected offset.
// - A pump phase of two conversion clocks precedes every sample phase.
// - Sampling goes through the buffer for exactly two clocks, then directly for the remaining sample time.
// - The input is disconnected from the storage node for the whole hold and conversion period.
// - Resolution is 8, 10 or 12 bits and each result has the selected width.
// - The result is found by successive approximation from the most significant bit down.
// - Inputs outside the reference range give an all-zero or all-one code, others unsaturated codes.
// - Exactly one selected input channel is connected to the storage node for each conversion.
// - The command fetch address is the command base plus the selected offset plus the command index.
// - While enabled without special mode access the list address registers are read-only and the index is advanced by the block.
`ifndef ADCLSO_MAP_VH
`define ADCLSO_MAP_VH

`define ADCLSO_IX_CTRL    6'h00
`define ADCLSO_IX_CBASE   6'h01
`define ADCLSO_IX_RBASE   6'h02
`define ADCLSO_IX_STAT    6'h03
`define ADCLSO_IX_RES     6'h04
`define ADCLSO_IX_OFFA    6'h24
`define ADCLSO_IX_OFFB    6'h25

`define ADCLSO_CTRL_EN    0
`define ADCLSO_CTRL_SMA   1
`define ADCLSO_CTRL_LSEL  2
`define ADCLSO_CTRL_GO    3

`define ADCLSO_CMD_CH     4:0
`define ADCLSO_CMD_RES    9:8
`define ADCLSO_CMD_SMP    14:10
`define ADCLSO_CMD_EOL    31

`define ADCLSO_RES_8      2'h0
`define ADCLSO_RES_10     2'h1
`define ADCLSO_LSB_8      12'h010
`define ADCLSO_LSB_10     12'h004
`define ADCLSO_LSB_12     12'h001
`define ADCLSO_MSB        12'h800

`define ADCLSO_PUMP_CYC   5'h02
`define ADCLSO_BUF_CYC    5'h02
`define ADCLSO_SMP_MIN    5'h04

`define ADCLSO_CBASE_MASK 24'hFFFFFC
`define ADCLSO_RBASE_MASK 20'hFFFFC
`define ADCLSO_OKAY       2'h0
`define ADCLSO_SLVERR     2'h2

`endif

// ==== rtl/adclso_sar.v ====
// Successive approximation search engine with selectable resolution.
// Assumes the comparator answers for the trial code presented in the same cycle.
`timescale 1ns/10ps
`include "adclso_map.vh"
module adclso_sar (
  // Clock and reset.
  input  wire        aclk,
  input  wire        aresetn,
  // Control.
  input  wire        start,
  input  wire [1:0]  res_sel,
  // Comparator, high while the held voltage is at or above the trial code.
  input  wire        comp,
  // Results.
  output reg  [11:0] trial_r,
  output reg  [11:0] result_r,
  output reg         busy_r,
  output reg         done_r
);
  reg  [11:0] bit_r;
  reg  [11:0] acc_r;
  reg  [11:0] lsb_r;
  wire [11:0] acc_nxt = comp ? trial_r : acc_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      bit_r    <= 12'h000;
      acc_r    <= 12'h000;
      lsb_r    <= `ADCLSO_LSB_12;
      trial_r  <= 12'h000;
      result_r <= 12'h000;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        bit_r   <= `ADCLSO_MSB;
        acc_r   <= 12'h000;
        trial_r <= `ADCLSO_MSB;
        busy_r  <= 1'b1;
        if (res_sel == `ADCLSO_RES_8) begin
          lsb_r <= `ADCLSO_LSB_8;
        end else if (res_sel == `ADCLSO_RES_10) begin
          lsb_r <= `ADCLSO_LSB_10;
        end else begin
          lsb_r <= `ADCLSO_LSB_12;
        end
      end else if (busy_r) begin
        // A comparator stuck high or low walks the code to all ones or all zeros.
        if (bit_r == lsb_r) begin
          busy_r  <= 1'b0;
          done_r  <= 1'b1;
          trial_r <= 12'h000;
          if (lsb_r == `ADCLSO_LSB_8) begin
            result_r <= {4'h0, acc_nxt[11:4]};
          end else if (lsb_r == `ADCLSO_LSB_10) begin
            result_r <= {2'h0, acc_nxt[11:2]};
          end else begin
            result_r <= acc_nxt;
          end
        end else begin
          bit_r   <= {1'b0, bit_r[11:1]};
          acc_r   <= acc_nxt;
          trial_r <= acc_nxt | {1'b0, bit_r[11:1]};
        end
      end
    end
  end
endmodule

// ==== rtl/adclso_top.v ====
// List offset registers, list addressing and conversion sequencer with an AXI4-Lite register slave.
// Assumes a memory port that acknowledges each held request with a one-cycle ack.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
`include "adclso_map.vh"
module adclso_top (
  // Clock and reset.
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address.
  input  wire        awvalid,
  output reg         awready_r,
  input  wire [7:0]  awaddr,
  input  wire [2:0]  awprot,
  // AXI4-Lite write data.
  input  wire        wvalid,
  output reg         wready_r,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  // AXI4-Lite write response.
  output reg         bvalid_r,
  input  wire        bready,
  output reg  [1:0]  bresp_r,
  // AXI4-Lite read address.
  input  wire        arvalid,
  output reg         arready_r,
  input  wire [7:0]  araddr,
  input  wire [2:0]  arprot,
  // AXI4-Lite read data.
  output reg         rvalid_r,
  input  wire        rready,
  output reg  [31:0] rdata_r,
  output reg  [1:0]  rresp_r,
  // Command fetch port.
  output reg         cmd_req_r,
  output reg  [23:0] cmd_addr_r,
  input  wire        cmd_ack,
  input  wire [31:0] cmd_data,
  // Result store port.
  output reg         res_req_r,
  output reg  [19:0] res_addr_r,
  output reg  [15:0] res_data_r,
  input  wire        res_ack,
  // Analog control.
  output reg         pump_on_r,
  output reg         buf_on_r,
  output reg         direct_on_r,
  output reg         hold_r,
  output reg         mux_en_r,
  output reg  [4:0]  mux_sel_r,
  output wire [11:0] sar_trial,
  input  wire        comp_in
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_FETCH = 3'h1;
  localparam ST_PUMP  = 3'h2;
  localparam ST_SBUF  = 3'h3;
  localparam ST_SDIR  = 3'h4;
  localparam ST_CONV  = 3'h5;
  localparam ST_STORE = 3'h6;

  // Register state.
  reg         en_r;
  reg         sma_r;
  reg         lsel_r;
  reg  [6:0]  offb_r;
  reg  [23:0] cbase_r;
  reg  [19:0] rbase_r;
  reg  [15:0] last_res_r;
  // Sequencer state.
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [4:0]  cnt_r;
  reg  [4:0]  cnt_nxt;
  reg  [5:0]  cidx_r;
  reg  [5:0]  cidx_nxt;
  reg  [5:0]  ridx_r;
  reg  [5:0]  ridx_nxt;
  reg  [31:0] cmd_r;
  reg  [31:0] cmd_nxt;
  reg         actb_r;
  reg         actb_nxt;
  reg         go_r;
  // Bus state.
  reg         aw_got_r;
  reg         w_got_r;
  reg  [7:0]  aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg  [31:0] rd_data;
  reg         rd_err;
  reg         wr_err;
  reg  [4:0]  smp_eff;

  wire        sar_busy;
  wire        sar_done;
  wire [11:0] sar_result;
  wire        sar_go = (state_r == ST_SDIR) && (cnt_r == 5'h00);
  wire        wr_do = aw_got_r & w_got_r & ~bvalid_r;
  wire        aw_got_nxt = (aw_got_r & ~wr_do) | (awvalid & awready_r);
  wire        w_got_nxt = (w_got_r & ~wr_do) | (wvalid & wready_r);
  wire        rvalid_nxt = (rvalid_r & ~rready) | (arvalid & arready_r);
  wire        addr_wr_ok = ~en_r | sma_r;
  wire [6:0]  off_sel = actb_nxt ? offb_r : 7'h00;
  wire [7:0]  c_slot = {1'b0, off_sel} + {2'h0, cidx_nxt};
  wire [7:0]  r_slot = {1'b0, off_sel} + {2'h0, ridx_nxt};
  wire [23:0] cmd_addr_nxt = cbase_r + {14'h0000, c_slot, 2'h0};
  wire [19:0] res_addr_nxt = rbase_r + {11'h000, r_slot, 1'b0};

  // Merges the enabled byte lanes of a write into the old value.
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      i;
    begin
      lane_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction
  wire [31:0] cbase_merged = lane_merge({8'h00, cbase_r}, w_data_r, w_strb_r);
  wire [31:0] rbase_merged = lane_merge({12'h000, rbase_r}, w_data_r, w_strb_r);

  adclso_sar u_sar (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (sar_go),
    .res_sel  (cmd_r[`ADCLSO_CMD_RES]),
    .comp     (comp_in),
    .trial_r  (sar_trial),
    .result_r (sar_result),
    .busy_r   (sar_busy),
    .done_r   (sar_done)
  );

  // Write channel acceptance and response.
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `ADCLSO_OKAY;
    end else begin
      awready_r <= ~aw_got_nxt;
      wready_r  <= ~w_got_nxt;
      aw_got_r  <= aw_got_nxt;
      w_got_r   <= w_got_nxt;
      if (awvalid & awready_r) begin
        aw_addr_r <= awaddr;
      end
      if (wvalid & wready_r) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_err ? `ADCLSO_SLVERR : `ADCLSO_OKAY;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Write address decode.
  always @* begin
    wr_err = 1'b1;
    if (aw_addr_r == {`ADCLSO_IX_CTRL, 2'h0} || aw_addr_r == {`ADCLSO_IX_CBASE, 2'h0} ||
        aw_addr_r == {`ADCLSO_IX_RBASE, 2'h0} || aw_addr_r == {`ADCLSO_IX_STAT, 2'h0} ||
        aw_addr_r == {`ADCLSO_IX_RES, 2'h0} || aw_addr_r == {`ADCLSO_IX_OFFA, 2'h0} ||
        aw_addr_r == {`ADCLSO_IX_OFFB, 2'h0}) begin
      wr_err = 1'b0;
    end
  end

  // Register writes.
  always @(posedge aclk) begin
    if (!aresetn) begin
      en_r    <= 1'b0;
      sma_r   <= 1'b0;
      lsel_r  <= 1'b0;
      go_r    <= 1'b0;
      offb_r  <= 7'h00;
      cbase_r <= 24'h000000;
      rbase_r <= 20'h00000;
    end else begin
      go_r <= 1'b0;
      if (wr_do && w_strb_r[0] && aw_addr_r == {`ADCLSO_IX_CTRL, 2'h0}) begin
        en_r   <= w_data_r[`ADCLSO_CTRL_EN];
        sma_r  <= w_data_r[`ADCLSO_CTRL_SMA];
        lsel_r <= w_data_r[`ADCLSO_CTRL_LSEL];
        go_r   <= w_data_r[`ADCLSO_CTRL_GO];
      end
      if (wr_do && addr_wr_ok && aw_addr_r == {`ADCLSO_IX_CBASE, 2'h0}) begin
        cbase_r <= cbase_merged[23:0] & `ADCLSO_CBASE_MASK;
      end
      if (wr_do && addr_wr_ok && aw_addr_r == {`ADCLSO_IX_RBASE, 2'h0}) begin
        rbase_r <= rbase_merged[19:0] & `ADCLSO_RBASE_MASK;
      end
      // A blocked write is acknowledged normally and leaves the offset as it was.
      if (wr_do && w_strb_r[0] && addr_wr_ok && aw_addr_r == {`ADCLSO_IX_OFFB, 2'h0}) begin
        offb_r <= w_data_r[6:0];
      end
    end
  end

  // Read data selection.
  always @* begin
    rd_data = 32'h00000000;
    rd_err  = 1'b0;
    if (araddr == {`ADCLSO_IX_CTRL, 2'h0}) begin
      rd_data = {29'h00000000, lsel_r, sma_r, en_r};
    end else if (araddr == {`ADCLSO_IX_CBASE, 2'h0}) begin
      rd_data = {8'h00, cbase_r};
    end else if (araddr == {`ADCLSO_IX_RBASE, 2'h0}) begin
      rd_data = {12'h000, rbase_r};
    end else if (araddr == {`ADCLSO_IX_STAT, 2'h0}) begin
      rd_data = {5'h00, state_r, 2'h0, ridx_r, 2'h0, cidx_r, 6'h00, actb_r, sar_busy};
    end else if (araddr == {`ADCLSO_IX_RES, 2'h0}) begin
      rd_data = {16'h0000, last_res_r};
    end else if (araddr == {`ADCLSO_IX_OFFA, 2'h0}) begin
      rd_data = 32'h00000000;
    end else if (araddr == {`ADCLSO_IX_OFFB, 2'h0}) begin
      rd_data = {25'h0000000, offb_r};
    end else begin
      rd_err = 1'b1;
    end
  end

  // Read channel.
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= `ADCLSO_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (arvalid & arready_r) begin
        rdata_r <= rd_data;
        rresp_r <= rd_err ? `ADCLSO_SLVERR : `ADCLSO_OKAY;
      end
    end
  end

  // Sequencer next state.
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    cidx_nxt  = cidx_r;
    ridx_nxt  = ridx_r;
    cmd_nxt   = cmd_r;
    actb_nxt  = actb_r;
    smp_eff   = (cmd_r[`ADCLSO_CMD_SMP] < `ADCLSO_SMP_MIN) ? `ADCLSO_SMP_MIN : cmd_r[`ADCLSO_CMD_SMP];
    if (!en_r) begin
      state_nxt = ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (go_r) begin
            state_nxt = ST_FETCH;
            cidx_nxt  = 6'h00;
            ridx_nxt  = 6'h00;
            actb_nxt  = lsel_r;
          end
        end
        ST_FETCH: begin
          if (cmd_ack) begin
            cmd_nxt   = cmd_data;
            state_nxt = ST_PUMP;
            cnt_nxt   = `ADCLSO_PUMP_CYC - 5'h01;
          end
        end
        ST_PUMP: begin
          if (cnt_r == 5'h00) begin
            state_nxt = ST_SBUF;
            cnt_nxt   = `ADCLSO_BUF_CYC - 5'h01;
          end else begin
            cnt_nxt = cnt_r - 5'h01;
          end
        end
        ST_SBUF: begin
          if (cnt_r == 5'h00) begin
            state_nxt = ST_SDIR;
            cnt_nxt   = smp_eff - `ADCLSO_BUF_CYC - 5'h01;
          end else begin
            cnt_nxt = cnt_r - 5'h01;
          end
        end
        ST_SDIR: begin
          if (cnt_r == 5'h00) begin
            state_nxt = ST_CONV;
          end else begin
            cnt_nxt = cnt_r - 5'h01;
          end
        end
        ST_CONV: begin
          if (sar_done) begin
            state_nxt = ST_STORE;
          end
        end
        ST_STORE: begin
          if (res_ack) begin
            cidx_nxt  = cidx_r + 6'h01;
            ridx_nxt  = ridx_r + 6'h01;
            state_nxt = cmd_r[`ADCLSO_CMD_EOL] ? ST_IDLE : ST_FETCH;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers, memory requests and analog controls.
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r     <= ST_IDLE;
      cnt_r       <= 5'h00;
      cidx_r      <= 6'h00;
      ridx_r      <= 6'h00;
      cmd_r       <= 32'h00000000;
      actb_r      <= 1'b0;
      cmd_req_r   <= 1'b0;
      cmd_addr_r  <= 24'h000000;
      res_req_r   <= 1'b0;
      res_addr_r  <= 20'h00000;
      res_data_r  <= 16'h0000;
      last_res_r  <= 16'h0000;
      pump_on_r   <= 1'b0;
      buf_on_r    <= 1'b0;
      direct_on_r <= 1'b0;
      hold_r      <= 1'b0;
      mux_en_r    <= 1'b0;
      mux_sel_r   <= 5'h00;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      cidx_r      <= cidx_nxt;
      ridx_r      <= ridx_nxt;
      cmd_r       <= cmd_nxt;
      actb_r      <= actb_nxt;
      cmd_req_r   <= (state_nxt == ST_FETCH);
      cmd_addr_r  <= cmd_addr_nxt;
      res_req_r   <= (state_nxt == ST_STORE);
      res_addr_r  <= res_addr_nxt;
      if (sar_done) begin
        res_data_r <= {4'h0, sar_result};
        last_res_r <= {4'h0, sar_result};
      end
      pump_on_r   <= (state_nxt == ST_PUMP);
      buf_on_r    <= (state_nxt == ST_SBUF);
      direct_on_r <= (state_nxt == ST_SDIR);
      hold_r      <= (state_nxt == ST_CONV);
      mux_en_r    <= (state_nxt == ST_SBUF) || (state_nxt == ST_SDIR);
      mux_sel_r   <= cmd_nxt[`ADCLSO_CMD_CH];
    end
  end
endmodule

// ==== sim/adclso_checker.sv ====
// Port assertions for the list offset and SAR control block.
// Assumes it is bound into adclso_top and sees only its ports.
`timescale 1ns/10ps
module adclso_checker (
  // Clock and reset.
  input wire        aclk,
  input wire        aresetn,
  // Read channels.
  input wire        arvalid,
  input wire        arready_r,
  input wire [7:0]  araddr,
  input wire        rvalid_r,
  input wire [31:0] rdata_r,
  // Memory ports.
  input wire        cmd_req_r,
  input wire [23:0] cmd_addr_r,
  input wire        cmd_ack,
  input wire        res_req_r,
  input wire [19:0] res_addr_r,
  input wire [15:0] res_data_r,
  input wire        res_ack,
  // Analog control.
  input wire        pump_on_r,
  input wire        buf_on_r,
  input wire        direct_on_r,
  input wire        hold_r,
  input wire        mux_en_r,
  input wire [11:0] sar_trial
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_offa_zero;
    arvalid && arready_r && araddr == 8'h90 |=> rvalid_r && rdata_r == 32'h0;
  endproperty
  a_offa_zero:
    assert property (p_offa_zero) else $error("offset A read not zero");
  property p_pump_two;
    $rose(pump_on_r) |-> pump_on_r[*2] ##1 (!pump_on_r && buf_on_r);
  endproperty
  a_pump_two:
    assert property (p_pump_two) else $error("pump phase length wrong");
  property p_buf_two;
    $rose(buf_on_r) |-> buf_on_r[*2] ##1 (!buf_on_r && direct_on_r);
  endproperty
  a_buf_two:
    assert property (p_buf_two) else $error("buffered sample length wrong");
  property p_hold_open;
    hold_r |-> !(pump_on_r || buf_on_r || direct_on_r || mux_en_r);
  endproperty
  a_hold_open:
    assert property (p_hold_open) else $error("input connected during hold");
  property p_one_path;
    (buf_on_r || direct_on_r) |-> mux_en_r && !(buf_on_r && direct_on_r);
  endproperty
  a_one_path:
    assert property (p_one_path) else $error("input path not single");
  property p_msb_first;
    $rose(hold_r) |-> ##[0:2] sar_trial == 12'h800;
  endproperty
  a_msb_first:
    assert property (p_msb_first) else $error("first trial not MSB");
  property p_cmd_stand;
    cmd_req_r && !cmd_ack |=> cmd_req_r && $stable(cmd_addr_r);
  endproperty
  a_cmd_stand:
    assert property (p_cmd_stand) else $error("fetch request not held");
  property p_res_stand;
    res_req_r && !res_ack |=> res_req_r && $stable(res_addr_r) && $stable(res_data_r);
  endproperty
  a_res_stand:
    assert property (p_res_stand) else $error("store request not held");
  property p_ack_drop;
    cmd_ack |=> !cmd_req_r;
  endproperty
  a_ack_drop:
    assert property (p_ack_drop) else $error("fetch request not released");
  property p_res_width;
    res_req_r |-> res_data_r[15:12] == 4'h0;
  endproperty
  a_res_width:
    assert property (p_res_width) else $error("result wider than 12 bits");
  c_pump: cover property ($rose(pump_on_r));
  c_store: cover property (res_req_r && res_ack);
  c_read: cover property (rvalid_r);
endmodule
bind adclso_top adclso_checker adclso_checker_inst (.aclk, .aresetn, .arvalid, .arready_r, .araddr,
  .rvalid_r, .rdata_r, .cmd_req_r, .cmd_addr_r, .cmd_ack, .res_req_r, .res_addr_r, .res_data_r,
  .res_ack, .pump_on_r, .buf_on_r, .direct_on_r, .hold_r, .mux_en_r, .sar_trial);

// ==== sim/adclso_mem_model.sv ====
// System memory and analog input model facing the block's memory ports.
// Assumes requests held until acknowledged; slow adds three wait cycles.
`timescale 1ns/10ps
module adclso_mem_model (
  // Clock, reset and pacing.
  input wire         aclk,
  input wire         aresetn,
  input wire         slow,
  // Command fetch.
  input wire         cmd_req_r,
  input wire  [23:0] cmd_addr_r,
  output reg         cmd_ack,
  output wire [31:0] cmd_data,
  // Result store.
  input wire         res_req_r,
  output reg         res_ack,
  // Analog input and comparator.
  input wire  [4:0]  mux_sel_r,
  input wire  [11:0] sar_trial,
  output wire        comp_in
);
  reg  [31:0] mem [0:255];
  reg  [2:0]  cwait;
  reg  [2:0]  rwait;
  wire [11:0] vin;
  wire [2:0]  dly;
  assign dly = slow ? 3'h3 : 3'h0;
  // Data not acknowledged shows inverted so a stale word is never taken.
  assign cmd_data = cmd_ack ? mem[cmd_addr_r[9:2]] : ~mem[cmd_addr_r[9:2]];
  // Channel 31 sits above the high reference, channel 0 at the low one.
  assign vin = (mux_sel_r == 5'h1F) ? 12'hFFF : (mux_sel_r == 5'h00) ? 12'h000 : {mux_sel_r, 7'h35};
  assign comp_in = vin >= sar_trial;
  always @(posedge aclk) begin
    if (!aresetn || cmd_ack || !cmd_req_r) begin
      cmd_ack <= 1'b0;
      cwait <= 3'h0;
    end else if (cwait == dly) begin
      cmd_ack <= 1'b1;
    end else begin
      cwait <= cwait + 3'h1;
    end
    if (!aresetn || res_ack || !res_req_r) begin
      res_ack <= 1'b0;
      rwait <= 3'h0;
    end else if (rwait == dly) begin
      res_ack <= 1'b1;
    end else begin
      rwait <= rwait + 3'h1;
    end
  end
endmodule

// ==== sim/adclso_top_bench.sv ====
// Self-checking bench for the list offset and SAR control block.
// Assumes the memory model answers the fetch and store ports.
`timescale 1ns/10ps
module adclso_top_bench;
  reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata;
  wire awready_r, wready_r, bvalid_r, arready_r, rvalid_r, cmd_req_r, cmd_ack, res_req_r, res_ack, comp_in;
  wire [1:0] bresp_r, rresp_r;
  wire [31:0] rdata_r, cmd_data;
  wire [23:0] cmd_addr_r;
  wire [19:0] res_addr_r;
  wire [15:0] res_data_r;
  wire [4:0] mux_sel_r;
  wire [11:0] sar_trial;
  wire pump_on_r, buf_on_r, direct_on_r, hold_r, mux_en_r;
  int err_total, samples_checked, ne, nc, nr;
  reg [23:0] exp_ca [0:7];
  reg [19:0] exp_ra [0:7];
  reg [15:0] exp_rd [0:7];
  reg [31:0] d;
  reg [1:0] r;
  adclso_top adclso_top_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready_r(awready_r),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready_r(wready_r), .wdata(wdata), .wstrb(4'hF),
    .bvalid_r(bvalid_r), .bready(bready), .bresp_r(bresp_r), .arvalid(arvalid), .arready_r(arready_r),
    .araddr(araddr), .arprot(3'h0), .rvalid_r(rvalid_r), .rready(rready), .rdata_r(rdata_r),
    .rresp_r(rresp_r), .cmd_req_r(cmd_req_r), .cmd_addr_r(cmd_addr_r), .cmd_ack(cmd_ack),
    .cmd_data(cmd_data), .res_req_r(res_req_r), .res_addr_r(res_addr_r), .res_data_r(res_data_r),
    .res_ack(res_ack), .pump_on_r(pump_on_r), .buf_on_r(buf_on_r), .direct_on_r(direct_on_r),
    .hold_r(hold_r), .mux_en_r(mux_en_r), .mux_sel_r(mux_sel_r), .sar_trial(sar_trial), .comp_in(comp_in));
  adclso_mem_model adclso_mem_model_inst (.aclk(aclk), .aresetn(aresetn), .slow(slow),
    .cmd_req_r(cmd_req_r), .cmd_addr_r(cmd_addr_r), .cmd_ack(cmd_ack), .cmd_data(cmd_data),
    .res_req_r(res_req_r), .res_ack(res_ack), .mux_sel_r(mux_sel_r), .sar_trial(sar_trial),
    .comp_in(comp_in));
  task automatic chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Write with address and data offered together, each released when taken.
  task wr(input [7:0] a, input [31:0] v);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready_r) awvalid <= 1'b0;
      if (wvalid && wready_r) wvalid <= 1'b0;
    end while (!bvalid_r);
    r = bresp_r;
    bready <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready_r) arvalid <= 1'b0;
    end while (!rvalid_r);
    d = rdata_r;
    r = rresp_r;
    rready <= 1'b0;
  endtask
  function [15:0] conv(input [4:0] ch, input [1:0] rs);
    reg [11:0] v;
    v = (ch == 5'h1F) ? 12'hFFF : (ch == 5'h00) ? 12'h000 : {ch, 7'h35};
    conv = (rs == 2'h0) ? {8'h0, v[11:4]} : (rs == 2'h1) ? {6'h0, v[11:2]} : {4'h0, v};
  endfunction
  // Places a command in memory at base 0x100 and records its fetch and store.
  task put(input [5:0] i, input [6:0] off, input e, input [4:0] smp, input [1:0] rs, input [4:0] ch);
    reg [23:0] ca;
    ca = 24'h100 + ({17'h0, off} + i) * 4;
    adclso_mem_model_inst.mem[ca[9:2]] = {e, 16'h0, smp, rs, 3'h0, ch};
    exp_ca[ne] = ca;
    exp_ra[ne] = 20'h200 + ({13'h0, off} + i) * 2;
    exp_rd[ne] = conv(ch, rs);
    ne++;
  endtask
  task wait_res(input int n);
    int i;
    for (i = 0; i < 3000 && nr < n; i++) @(posedge aclk);
    chk(nr, n);
  endtask
  always @(posedge aclk) begin
    if (cmd_req_r && cmd_ack) begin
      chk(cmd_addr_r, exp_ca[nc]);
      nc++;
    end
    if (res_req_r && res_ack) begin
      chk(res_addr_r, exp_ra[nr]);
      chk(res_data_r, exp_rd[nr]);
      nr++;
    end
  end
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    report_and_stop;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = 7'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    wr(8'h90, 32'hFFFFFFFF);
    rd(8'h90);
    chk(d, 32'h0);
    wr(8'h94, 32'h0000FFFF);
    rd(8'h94);
    chk(d, 32'h7F);
    rd(8'h40);
    chk(r, 2'h2);
    wr(8'h40, 32'h1);
    chk(r, 2'h2);
    wr(8'h04, 32'h100);
    wr(8'h08, 32'h200);
    wr(8'h94, 32'h5);
    put(6'h0, 7'h5, 1'b0, 5'h04, 2'h2, 5'h03);
    put(6'h1, 7'h5, 1'b0, 5'h06, 2'h0, 5'h1F);
    put(6'h2, 7'h5, 1'b1, 5'h03, 2'h1, 5'h00);
    wr(8'h00, 32'h5);
    wr(8'h00, 32'hD);
    wr(8'h94, 32'h11);
    chk(r, 2'h0);
    wr(8'h04, 32'h300);
    rd(8'h94);
    chk(d, 32'h5);
    rd(8'h04);
    chk(d, 32'h100);
    wait_res(3);
    wr(8'h00, 32'h7);
    wr(8'h94, 32'h9);
    rd(8'h94);
    chk(d, 32'h9);
    wr(8'h00, 32'h0);
    slow <= 1'b1;
    put(6'h0, 7'h0, 1'b1, 5'h08, 2'h1, 5'h05);
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h9);
    wait_res(4);
    rd(8'h10);
    chk(d, {16'h0, exp_rd[3]});
    rd(8'h0C);
    chk(d, 32'h00010100);
    report_and_stop;
  end
endmodule
